/* File: hdl/epo_energy_pulse_outputs.sv */
// Purpose: pulse output stage of an energy meter, two staggered average-power
//   outputs and one calibration output
// Assumes: energy quanta arrive as one-cycle pulses from the conversion logic
// Notes: output frequency comes from the energy accumulator, widths here
`timescale 1ns/1ps
`default_nettype none
`include "epo_map.svh"

module epo_energy_pulse_outputs #(
  parameter int unsigned CNT_W = 32,
  parameter logic [31:0] AVG_LOW_CYC = 32'(`EPO_AVG_LOW_CYC),
  parameter logic [31:0] CAL_HIGH_CYC = 32'(`EPO_CAL_HIGH_CYC),
  parameter logic [31:0] CAL_HF_HIGH_CYC = 32'(`EPO_CAL_HF_HIGH_CYC),
  // energy quanta per average-power pulse for each rate select code
  parameter logic [31:0] AVG_DIV_0 = 32'h0000_0800,
  parameter logic [31:0] AVG_DIV_1 = 32'h0000_0400,
  parameter logic [31:0] AVG_DIV_2 = 32'h0000_0200,
  parameter logic [31:0] AVG_DIV_3 = 32'h0000_0100,
  // quanta per calibration pulse, normal and high-frequency selection
  parameter logic [31:0] CAL_DIV_NORM = 32'h0000_0010,
  parameter logic [31:0] CAL_DIV_HF = 32'h0000_0001
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // energy quanta
  input wire logic inst_quantum_i,
  input wire logic avg_quantum_i,
  // selects
  input wire logic rate_select_hi_i,
  input wire logic rate_select_lo_i,
  input wire logic calib_rate_select_i,
  // pulse outputs
  output logic avg_power_pulse_a_n_o,
  output logic avg_power_pulse_b_n_o,
  output logic calib_pulse_out_o
);

  // ---------------------------------------------------------------------------
  // rate decode
  // ---------------------------------------------------------------------------
  wire epo_pkg::epo_rate_e rate_sel = epo_pkg::epo_rate_e'({rate_select_hi_i, rate_select_lo_i});
  wire logic [31:0] avg_div = (rate_sel == epo_pkg::EPO_RATE_0) ? AVG_DIV_0 :
                              (rate_sel == epo_pkg::EPO_RATE_1) ? AVG_DIV_1 :
                              (rate_sel == epo_pkg::EPO_RATE_2) ? AVG_DIV_2 : AVG_DIV_3;
  wire logic [31:0] cal_div = calib_rate_select_i ? CAL_DIV_HF : CAL_DIV_NORM;
  wire logic [31:0] cal_width = calib_rate_select_i ? CAL_HF_HIGH_CYC : CAL_HIGH_CYC;

  // ---------------------------------------------------------------------------
  // quantum accumulators
  // ---------------------------------------------------------------------------
  logic [31:0] avg_acc_q;
  logic [31:0] cal_acc_q;
  // half-period events alternate between output a and output b
  wire logic avg_half = avg_quantum_i && (avg_acc_q + 32'h1 >= (avg_div >> 1));
  wire logic cal_evt = inst_quantum_i && (cal_acc_q + 32'h1 >= cal_div);

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avg_acc_q <= 32'h0;
      cal_acc_q <= 32'h0;
    end else begin
      if (avg_quantum_i) avg_acc_q <= avg_half ? 32'h0 : avg_acc_q + 32'h1;
      if (inst_quantum_i) cal_acc_q <= cal_evt ? 32'h0 : cal_acc_q + 32'h1;
    end
  end

  // ---------------------------------------------------------------------------
  // period measurement for width shrinking
  // ---------------------------------------------------------------------------
  logic [31:0] avg_gap_q;
  logic [31:0] avg_last_q;
  logic [31:0] cal_gap_q;
  logic [31:0] cal_last_q;
  logic turn_b_q;
  // spacing counts only after a first event, so time since reset never passes for a period
  wire logic avg_gap_hold = avg_gap_q == 32'h0 || avg_gap_q == 32'hffff_ffff;
  wire logic cal_gap_hold = cal_gap_q == 32'h0 || cal_gap_q == 32'hffff_ffff;
  // half the last spacing, never below one cycle
  wire logic [31:0] avg_fit = (avg_last_q < 32'h2) ? 32'h1 : (avg_last_q >> 1);
  wire logic [31:0] cal_fit = (cal_last_q < 32'h2) ? 32'h1 : (cal_last_q >> 1);
  // a pulse may take at most half of the last measured spacing
  wire logic [31:0] avg_width = (avg_last_q != 32'h0 && avg_fit < AVG_LOW_CYC) ?
                                avg_fit : AVG_LOW_CYC;
  wire logic [31:0] cal_eff = (cal_last_q != 32'h0 && cal_fit < cal_width) ?
                              cal_fit : cal_width;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avg_gap_q <= 32'h0;
      avg_last_q <= 32'h0;
      cal_gap_q <= 32'h0;
      cal_last_q <= 32'h0;
      turn_b_q <= 1'b0;
    end else begin
      avg_gap_q <= avg_half ? 32'h1 : (avg_gap_hold ? avg_gap_q : avg_gap_q + 32'h1);
      cal_gap_q <= cal_evt ? 32'h1 : (cal_gap_hold ? cal_gap_q : cal_gap_q + 32'h1);
      if (avg_half) begin
        avg_last_q <= avg_gap_q;
        turn_b_q <= !turn_b_q;
      end
      if (cal_evt) cal_last_q <= cal_gap_q;
    end
  end

  // ---------------------------------------------------------------------------
  // pulse width timers
  // ---------------------------------------------------------------------------
  logic [31:0] a_cnt_q;
  logic [31:0] b_cnt_q;
  logic [31:0] c_cnt_q;
  wire logic start_a = avg_half && !turn_b_q;
  wire logic start_b = avg_half && turn_b_q;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      a_cnt_q <= 32'h0;
      b_cnt_q <= 32'h0;
      c_cnt_q <= 32'h0;
      avg_power_pulse_a_n_o <= 1'b1;
      avg_power_pulse_b_n_o <= 1'b1;
      calib_pulse_out_o <= 1'b0;
    end else begin
      if (start_a) begin
        a_cnt_q <= avg_width - 32'h1;
        avg_power_pulse_a_n_o <= 1'b0;
      end else if (a_cnt_q != 32'h0) begin
        a_cnt_q <= a_cnt_q - 32'h1;
      end else begin
        avg_power_pulse_a_n_o <= 1'b1;
      end
      if (start_b) begin
        b_cnt_q <= avg_width - 32'h1;
        avg_power_pulse_b_n_o <= 1'b0;
      end else if (b_cnt_q != 32'h0) begin
        b_cnt_q <= b_cnt_q - 32'h1;
      end else begin
        avg_power_pulse_b_n_o <= 1'b1;
      end
      if (cal_evt) begin
        c_cnt_q <= cal_eff - 32'h1;
        calib_pulse_out_o <= 1'b1;
      end else if (c_cnt_q != 32'h0) begin
        c_cnt_q <= c_cnt_q - 32'h1;
      end else begin
        calib_pulse_out_o <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // check helpers
  // ---------------------------------------------------------------------------
  // width loaded at each launch and active cycles counted since that launch
  logic [31:0] a_load_q;
  logic [31:0] a_run_q;
  logic [31:0] b_load_q;
  logic [31:0] b_run_q;
  logic [31:0] c_load_q;
  logic [31:0] c_run_q;
  logic last_a_q;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      a_load_q <= 32'h0;
      a_run_q <= 32'h0;
      b_load_q <= 32'h0;
      b_run_q <= 32'h0;
      c_load_q <= 32'h0;
      c_run_q <= 32'h0;
      last_a_q <= 1'b0;
    end else begin
      if (start_a) a_load_q <= avg_width;
      if (start_b) b_load_q <= avg_width;
      if (cal_evt) c_load_q <= cal_eff;
      a_run_q <= start_a ? 32'h0 : (avg_power_pulse_a_n_o ? a_run_q : a_run_q + 32'h1);
      b_run_q <= start_b ? 32'h0 : (avg_power_pulse_b_n_o ? b_run_q : b_run_q + 32'h1);
      c_run_q <= cal_evt ? 32'h0 : (calib_pulse_out_o ? c_run_q + 32'h1 : c_run_q);
      if (start_a || start_b) last_a_q <= start_a;
    end
  end

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  sequence s_a_low;
    !avg_power_pulse_a_n_o;
  endsequence
  sequence s_c_high;
    calib_pulse_out_o;
  endsequence

  a_avg_a_start: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    start_a |=> !avg_power_pulse_a_n_o && a_cnt_q == $past(avg_width) - 32'h1)
    else $error("output a pulse did not start with its width");
  a_avg_b_start: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    start_b |=> !avg_power_pulse_b_n_o)
    else $error("output b pulse did not start");
  a_avg_alternate: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    avg_half |=> turn_b_q != $past(turn_b_q))
    else $error("half-period turn did not alternate");
  a_cal_start: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    cal_evt |=> calib_pulse_out_o && c_cnt_q == $past(cal_eff) - 32'h1)
    else $error("calibration pulse did not start with its width");
  a_cal_hf_width: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    calib_rate_select_i && cal_last_q == 32'h0 |-> cal_eff == CAL_HF_HIGH_CYC)
    else $error("high-frequency calibration width wrong");
  a_width_shrink: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    avg_last_q != 32'h0 |-> avg_width <= AVG_LOW_CYC && avg_width <= (avg_last_q >> 1) + 32'h1)
    else $error("average width not shrunk to fit");
  a_rate_decode: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    {rate_select_hi_i, rate_select_lo_i} == 2'b11 |-> avg_div == AVG_DIV_3)
    else $error("rate select decode wrong");
  a_cal_idle: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    c_cnt_q == 32'h0 && !cal_evt |=> !calib_pulse_out_o)
    else $error("calibration output not idle low");
  a_avg_idle: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    a_cnt_q == 32'h0 && !start_a |=> avg_power_pulse_a_n_o)
    else $error("output a not idle high");
  a_b_idle: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    b_cnt_q == 32'h0 && !start_b |=> avg_power_pulse_b_n_o)
    else $error("output b not idle high");
  a_a_low_width: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(avg_power_pulse_a_n_o) |-> a_run_q == a_load_q && a_load_q != 32'h0 && a_load_q <= AVG_LOW_CYC)
    else $error("output a low time differs from its width");
  a_b_low_width: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(avg_power_pulse_b_n_o) |-> b_run_q == b_load_q && b_load_q != 32'h0 && b_load_q <= AVG_LOW_CYC)
    else $error("output b low time differs from its width");
  a_cal_high_width: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $fell(calib_pulse_out_o) |-> c_run_q == c_load_q && c_load_q != 32'h0 &&
      (c_load_q <= CAL_HIGH_CYC || c_load_q <= CAL_HF_HIGH_CYC))
    else $error("calibration high time differs from its width");
  a_launch_order: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (start_a || start_b) |-> start_b == last_a_q)
    else $error("average outputs did not launch in turn");
  a_a_low_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    start_a && avg_width > 32'h2 |=> s_a_low ##1 s_a_low)
    else $error("output a pulse not held low");
  a_cal_high_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    cal_evt && cal_eff > 32'h2 |=> s_c_high ##1 s_c_high)
    else $error("calibration pulse not held high");
  a_cal_quiet: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !inst_quantum_i && c_cnt_q == 32'h0 |=> !calib_pulse_out_o)
    else $error("calibration pulse without instantaneous quantum");
  a_cal_shrink: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    cal_last_q != 32'h0 |-> cal_eff <= cal_width && cal_eff <= (cal_last_q >> 1) + 32'h1)
    else $error("calibration width not shrunk to fit");

endmodule
`default_nettype wire

/* File: pkg/epo_map.svh */
// Purpose: constants for the energy pulse output stage
// Assumes: core clock of 200 MHz (5 ns period)
// Notes: times kept in their printed units, cycle counts derived from them
`ifndef EPO_MAP_SVH
`define EPO_MAP_SVH

`define EPO_CLK_PERIOD_PS 5000
`define EPO_AVG_LOW_MS 550
`define EPO_CAL_HIGH_MS 180
`define EPO_CAL_HF_HIGH_US 18
// least times round up to whole cycles
`define EPO_AVG_LOW_CYC ((`EPO_AVG_LOW_MS * 64'd1000000000 + `EPO_CLK_PERIOD_PS - 1) / `EPO_CLK_PERIOD_PS)
`define EPO_CAL_HIGH_CYC ((`EPO_CAL_HIGH_MS * 64'd1000000000 + `EPO_CLK_PERIOD_PS - 1) / `EPO_CLK_PERIOD_PS)
`define EPO_CAL_HF_HIGH_CYC ((`EPO_CAL_HF_HIGH_US * 64'd1000000 + `EPO_CLK_PERIOD_PS - 1) / `EPO_CLK_PERIOD_PS)

`endif

/* File: pkg/epo_pkg.sv */
// Purpose: types for the energy pulse output stage
// Assumes: nothing
// Notes: rate select codes of the two select inputs
`default_nettype none
package epo_pkg;
  typedef enum logic [1:0] {
    EPO_RATE_0 = 2'b00,
    EPO_RATE_1 = 2'b01,
    EPO_RATE_2 = 2'b10,
    EPO_RATE_3 = 2'b11
  } epo_rate_e;
  typedef logic [31:0] epo_cnt_t;
endpackage
`default_nettype wire

/* File: sim/epo_counter_model.sv */
// Purpose: far-side pulse counter
// Assumes: pulses sampled on the falling core clock edge, where they are settled
// Notes: keeps the last width of each pulse
`timescale 1ns/1ps
`default_nettype none
module epo_counter_model (
  // clock
  input wire logic core_clk_i,
  // pulses
  input wire logic avg_a_n_i,
  input wire logic calib_i,
  // measured widths
  output var int avg_w_o,
  output var int cal_w_o
);
  int ra = 0;
  int rc = 0;
  initial avg_w_o = 0;
  initial cal_w_o = 0;
  always @(negedge core_clk_i) begin
    if (!avg_a_n_i) ra++;
    else if (ra > 0) begin
      avg_w_o = ra;
      ra = 0;
    end
    if (calib_i) rc++;
    else if (rc > 0) begin
      cal_w_o = rc;
      rc = 0;
    end
  end
endmodule
`default_nettype wire

/* File: sim/energy_pulse_outputs_bench.sv */
// Purpose: self-checking bench for the pulse stage
// Assumes: short widths 20, 10 and 4 cycles
// Notes: integer model compared every cycle except in the quick run
`timescale 1ns/1ps
`default_nettype none
module energy_pulse_outputs_bench;
  localparam int AW = 20;
  localparam int CW = 10;
  localparam int HW = 4;
  // the two upper codes and both calibration divisors keep the design's own values
  localparam int DIV[4] = '{64, 32, 512, 256};
  logic clk = 0, rst_n = 0, inq = 0, avq = 0, shi = 0, slo = 0, csel = 0;
  logic a_n, b_n, cal;
  int errors = 0, tests_run = 0, cyc = 0, wa, wc;
  int ac, cc, ta, tb, tc;
  bit ea, ec, tog, fast;
  epo_energy_pulse_outputs #(.AVG_LOW_CYC(32'h14), .CAL_HIGH_CYC(32'ha), .CAL_HF_HIGH_CYC(32'h4),
    .AVG_DIV_0(32'h40), .AVG_DIV_1(32'h20)) uut (.core_clk_i(clk), .rst_n_i(rst_n),
    .inst_quantum_i(inq), .avg_quantum_i(avq), .rate_select_hi_i(shi), .rate_select_lo_i(slo),
    .calib_rate_select_i(csel), .avg_power_pulse_a_n_o(a_n), .avg_power_pulse_b_n_o(b_n),
    .calib_pulse_out_o(cal));
  epo_counter_model far (.core_clk_i(clk), .avg_a_n_i(a_n), .calib_i(cal), .avg_w_o(wa), .cal_w_o(wc));
  // ----
  // model
  // ----
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {ac, cc, ta, tb, tc} = '0;
      {ea, ec, tog} = '0;
    end else begin
      ac = ac + avq;
      cc = cc + inq;
      ea = ac >= DIV[{shi, slo}] / 2;
      ec = cc >= (csel ? 1 : 16);
      if (ea) ac = 0;
      if (ec) cc = 0;
      ta = (ea && !tog) ? AW : ta - (ta > 0);
      tb = (ea && tog) ? AW : tb - (tb > 0);
      tc = ec ? (csel ? HW : CW) : tc - (tc > 0);
      tog = tog ^ ea;
    end
  end
  task automatic check(input string n, input logic seen, input logic exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %0b seen %0b", n, exp, seen);
    end
  endtask
  always @(negedge clk) if (!fast) begin
    check("avg a", a_n, ta == 0);
    check("avg b", b_n, tb == 0);
    check("calib", cal, tc != 0);
  end
  task automatic report_and_stop();
    if (errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ----
  // stimulus
  // ----
  task automatic run(input logic [1:0] code, input logic hf, input bit quick);
    int n;
    @(posedge clk);
    #1 rst_n = 0;
    {shi, slo} = code;
    csel = hf;
    fast = quick;
    repeat (3) @(posedge clk);
    #1 rst_n = 1;
    n = quick ? 100 : DIV[code] + 8;
    repeat (n) begin
      @(posedge clk);
      #1 avq = 1;
      inq = quick | 1'($urandom_range(1));
      @(posedge clk);
      #1 avq = 0;
      inq = 0;
      // spacing kept wide so full widths fit
      if (!quick) repeat (10 + $urandom_range(3)) @(posedge clk);
    end
    repeat (50) @(posedge clk);
  endtask
  initial begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      report_and_stop();
    end
  end
  initial begin
    void'($urandom(32'h2640));
    for (int m = 0; m < 8; m++) run(m[1:0], m[2], 0);
    run(2'b01, 1'b1, 1);
    check("avg shrink", wa > 0 && wa < AW, 1'b1);
    check("cal shrink", wc > 0 && wc < HW, 1'b1);
    report_and_stop();
  end
endmodule
`default_nettype wire
